// >>> core/isrp_if.sv
/*
  Open-drain two-wire bus joining the master end and the slave end.
  Assumes each end drives a wire low only while its enable is high.
*/
`timescale 1ns/100ps
interface isrp_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_scl_o;
  logic s_scl_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // ****************************************
  // Wired-and resolution
  // ****************************************
  assign scl = ~(m_scl_oe & ~m_scl_o) & ~(s_scl_oe & ~s_scl_o);
  assign sda = ~(m_sda_oe & ~m_sda_o) & ~(s_sda_oe & ~s_sda_o);
  modport master (input scl, input sda, output m_scl_o, output m_scl_oe,
    output m_sda_o, output m_sda_oe);
  modport slave (input scl, input sda, output s_scl_o, output s_scl_oe,
    output s_sda_o, output s_sda_oe);
endinterface

// >>> core/isrp_master.sv
/*
  Master end: runs one word write or one word read per command.
  Assumes cmd_* stays steady while cmd_valid is high and cmd_ready low.
*/
`timescale 1ns/100ps
module isrp_master #(
  parameter logic [6:0] SLV_ADDR = isrp_pkg::DEV_ADDR,
  parameter int QTR = isrp_pkg::QTR_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  isrp_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_rw,
  input wire logic [7:0] cmd_reg,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic done,
  output logic [15:0] rd_data,
  output logic nack_err
);
  typedef struct packed {
    logic sda1;
    logic sda2;
    isrp_pkg::isrp_mst_t st;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] cnt;
    logic [3:0] step;
    logic rw;
    logic [7:0] rg;
    logic [15:0] wd;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [15:0] rd;
    logic ackout;
    logic scl_oe;
    logic sda_oe;
    logic ready;
    logic done;
    logic err;
    logic zero;
  } isrp_mst_st_t;

  isrp_mst_st_t r;
  isrp_mst_st_t next_r;
  logic tick;
  logic [3:0] nstep;

  // ****************************************
  // Sequence plan per command
  // ****************************************
  function automatic isrp_pkg::isrp_mst_t isrp_plan(input logic rw, input logic [3:0] s);
    isrp_pkg::isrp_mst_t k;
    k = isrp_pkg::ISRP_M_IDLE;
    case (s)
      4'h0: k = isrp_pkg::ISRP_M_START;
      4'h1, 4'h2: k = isrp_pkg::ISRP_M_WBYTE;
      4'h3: k = rw ? isrp_pkg::ISRP_M_START : isrp_pkg::ISRP_M_WBYTE;
      4'h4: k = isrp_pkg::ISRP_M_WBYTE;
      4'h5: k = rw ? isrp_pkg::ISRP_M_RBYTE : isrp_pkg::ISRP_M_STOP;
      4'h6: k = rw ? isrp_pkg::ISRP_M_RBYTE : isrp_pkg::ISRP_M_IDLE;
      4'h7: k = rw ? isrp_pkg::ISRP_M_STOP : isrp_pkg::ISRP_M_IDLE;
      default: k = isrp_pkg::ISRP_M_IDLE;
    endcase
    return k;
  endfunction

  function automatic logic [7:0] isrp_byte(input logic rw, input logic [3:0] s,
    input logic [7:0] rg, input logic [15:0] wd);
    logic [7:0] b;
    b = {SLV_ADDR, isrp_pkg::RW_WRITE};
    case (s)
      4'h2: b = rg;
      4'h3: b = wd[15:8];
      4'h4: b = rw ? {SLV_ADDR, isrp_pkg::RW_READ} : wd[7:0];
      default: b = {SLV_ADDR, isrp_pkg::RW_WRITE};
    endcase
    return b;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.sda1 = bus.sda;
    next_r.sda2 = r.sda1;
    next_r.done = 1'b0;
    tick = (r.div == 16'(QTR - 1));
    nstep = r.step + 4'h1;
    next_r.div = tick ? 16'h0000 : r.div + 16'h0001;
    if (r.st == isrp_pkg::ISRP_M_IDLE) begin
      next_r.div = 16'h0000;
      next_r.ready = 1'b1;
      if (cmd_valid && r.ready) begin
        next_r.ready = 1'b0;
        next_r.err = 1'b0;
        next_r.rw = cmd_rw;
        next_r.rg = cmd_reg;
        next_r.wd = cmd_wdata;
        next_r.step = 4'h0;
        next_r.q = 2'h0;
        next_r.st = isrp_pkg::ISRP_M_START;
      end
    end else if (tick) begin
      next_r.q = r.q + 2'h1;
      unique case (r.q)
        2'h0: next_r.scl_oe = 1'b1;
        2'h1: begin
          if (r.st == isrp_pkg::ISRP_M_START) begin
            next_r.sda_oe = 1'b0;
          end else if (r.st == isrp_pkg::ISRP_M_STOP) begin
            next_r.sda_oe = 1'b1;
          end else if (r.cnt < isrp_pkg::BIT_ACK) begin
            next_r.sda_oe = (r.st == isrp_pkg::ISRP_M_WBYTE) & ~r.tx[7];
          end else begin
            next_r.sda_oe = (r.st == isrp_pkg::ISRP_M_RBYTE) & r.ackout;
          end
        end
        2'h2: next_r.scl_oe = 1'b0;
        2'h3: begin
          if (r.st == isrp_pkg::ISRP_M_START || r.st == isrp_pkg::ISRP_M_STOP) begin
            next_r.sda_oe = (r.st == isrp_pkg::ISRP_M_START);
          end else if (r.cnt < isrp_pkg::BIT_ACK) begin
            next_r.rx = {r.rx[6:0], r.sda2};
            next_r.tx = {r.tx[6:0], 1'b0};
          end else if (r.st == isrp_pkg::ISRP_M_WBYTE && r.sda2) begin
            next_r.err = 1'b1;
            next_r.st = isrp_pkg::ISRP_M_STOP;
            next_r.cnt = 4'h0;
          end else if (r.st == isrp_pkg::ISRP_M_RBYTE) begin
            if (r.ackout) begin
              next_r.rd[15:8] = r.rx;
            end else begin
              next_r.rd[7:0] = r.rx;
            end
          end
          if (r.st == isrp_pkg::ISRP_M_WBYTE || r.st == isrp_pkg::ISRP_M_RBYTE) begin
            next_r.cnt = r.cnt + 4'h1;
          end
          if (next_r.st == isrp_pkg::ISRP_M_STOP && r.st != isrp_pkg::ISRP_M_STOP) begin
            next_r.st = isrp_pkg::ISRP_M_STOP;
          end else if (r.st == isrp_pkg::ISRP_M_STOP) begin
            next_r.st = isrp_pkg::ISRP_M_IDLE;
            next_r.done = 1'b1;
          end else if (r.st == isrp_pkg::ISRP_M_START || r.cnt == isrp_pkg::BIT_ACK) begin
            next_r.cnt = 4'h0;
            next_r.step = nstep;
            next_r.st = isrp_plan(r.rw, nstep);
            next_r.tx = isrp_byte(r.rw, nstep, r.rg, r.wd);
            next_r.ackout = (nstep == isrp_pkg::RD_HI_STEP);
            if (isrp_plan(r.rw, nstep) == isrp_pkg::ISRP_M_IDLE) begin
              next_r.done = 1'b1;
            end
          end
        end
        default: next_r.q = 2'h0;
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign bus.m_scl_o = r.zero;
  assign bus.m_scl_oe = r.scl_oe;
  assign bus.m_sda_o = r.zero;
  assign bus.m_sda_oe = r.sda_oe;
  assign cmd_ready = r.ready;
  assign done = r.done;
  assign rd_data = r.rd;
  assign nack_err = r.err;
endmodule

// >>> core/isrp_pkg.sv
/*
  Shared constants and types for the two-wire register port, both ends.
  Assumes a single 25 MHz core clock on each end and open-drain bus wires.
*/
// Contract
// - Device is slave only, never starts
// - Start: SDA falls while SCL high
// - First byte: 7-bit address MSB first, direction
// - Matching address acked low before ninth pulse
// - Mismatch: stay idle, SDA released
// - Direction 0 writes, 1 reads
// - Nine pulses per byte, receiver acks
// - SDA changes at SCL low; rise is stop
// - No limit on bytes per operation
// - Master ends write with stop
// - Master ends read with nack then stop
// - Direction holds until next start
// - First write byte loads register pointer
// - Later write bytes go to pointed register
// - Device acks register address byte
// - Read: write pointer, repeated start, read
// - Read sends high byte then low byte
// - Single read: master nacks low byte
// - Write word: high then low, both acked
// - Master always writes both bytes
// - Acked low byte continues with next word (in a write the code takes the next byte as a new pointer)
package isrp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 2000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // ****************************************
  // Protocol
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_END = 4'h9;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] RD_HI_STEP = 4'h5;
  typedef enum logic [1:0] {ISRP_IDLE, ISRP_ADDR, ISRP_WRITE, ISRP_READ} isrp_phase_t;
  typedef enum logic [1:0] {ISRP_PTR, ISRP_HI, ISRP_LO} isrp_wsel_t;
  typedef enum logic [2:0] {
    ISRP_M_IDLE, ISRP_M_START, ISRP_M_WBYTE, ISRP_M_RBYTE, ISRP_M_STOP
  } isrp_mst_t;
endpackage

// >>> core/isrp_slave.sv
/*
  Slave end: decodes start/stop, own address, pointer and word access.
  Assumes the user side answers rd_data for ptr combinationally on clk.
*/
`timescale 1ns/100ps
module isrp_slave #(
  parameter logic [6:0] SLV_ADDR = isrp_pkg::DEV_ADDR
) (
  input wire logic clk,
  input wire logic sys_rst,
  isrp_if.slave bus,
  output logic [7:0] ptr,
  input wire logic [15:0] rd_data,
  output logic [7:0] wr_addr,
  output logic [15:0] wr_data,
  output logic wr_stb
);
  typedef struct packed {
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    isrp_pkg::isrp_phase_t ph;
    isrp_pkg::isrp_wsel_t ws;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] hold;
    logic lo_next;
    logic [7:0] ptr;
    logic [7:0] hi;
    logic sda_oe;
    logic [7:0] wa;
    logic [15:0] wd;
    logic stb;
    logic zero;
  } isrp_slv_t;

  isrp_slv_t r;
  isrp_slv_t next_r;
  logic rise;
  logic fall;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_r = r;
    next_r.scl1 = bus.scl;
    next_r.scl2 = r.scl1;
    next_r.scl3 = r.scl2;
    next_r.sda1 = bus.sda;
    next_r.sda2 = r.sda1;
    next_r.sda3 = r.sda2;
    next_r.stb = 1'b0;
    rise = r.scl2 & ~r.scl3;
    fall = ~r.scl2 & r.scl3;
    if (r.scl2 && r.scl3 && !r.sda2 && r.sda3) begin
      next_r.ph = isrp_pkg::ISRP_ADDR;
      next_r.cnt = 4'h0;
      next_r.sda_oe = 1'b0;
    end else if (r.scl2 && r.scl3 && r.sda2 && !r.sda3) begin
      next_r.ph = isrp_pkg::ISRP_IDLE;
      next_r.sda_oe = 1'b0;
    end else if (r.ph != isrp_pkg::ISRP_IDLE) begin
      if (rise) begin
        if (r.cnt < isrp_pkg::BIT_ACK) begin
          next_r.sh = {r.sh[6:0], r.sda2};
        end else if (r.ph == isrp_pkg::ISRP_READ && r.sda2) begin
          next_r.ph = isrp_pkg::ISRP_IDLE;
        end
        next_r.cnt = r.cnt + 4'h1;
      end else if (fall) begin
        case (r.cnt)
          isrp_pkg::BIT_ACK: begin
            next_r.sda_oe = 1'b0;
            if (r.ph == isrp_pkg::ISRP_ADDR) begin
              if (r.sh[7:1] == SLV_ADDR) begin
                next_r.sda_oe = 1'b1;
                next_r.ph = (r.sh[0] == isrp_pkg::RW_READ) ? isrp_pkg::ISRP_READ :
                  isrp_pkg::ISRP_WRITE;
                next_r.ws = isrp_pkg::ISRP_PTR;
                next_r.lo_next = 1'b0;
              end else begin
                next_r.ph = isrp_pkg::ISRP_IDLE;
              end
            end else if (r.ph == isrp_pkg::ISRP_WRITE) begin
              next_r.sda_oe = 1'b1;
              unique case (r.ws)
                isrp_pkg::ISRP_PTR: begin
                  next_r.ptr = r.sh;
                  next_r.ws = isrp_pkg::ISRP_HI;
                end
                isrp_pkg::ISRP_HI: begin
                  next_r.hi = r.sh;
                  next_r.ws = isrp_pkg::ISRP_LO;
                end
                isrp_pkg::ISRP_LO: begin
                  next_r.wa = r.ptr;
                  next_r.wd = {r.hi, r.sh};
                  next_r.stb = 1'b1;
                  next_r.ws = isrp_pkg::ISRP_PTR;
                end
                default: next_r.ws = isrp_pkg::ISRP_PTR;
              endcase
            end
          end
          isrp_pkg::BIT_END: begin
            next_r.cnt = 4'h0;
            next_r.sda_oe = 1'b0;
            if (r.ph == isrp_pkg::ISRP_READ) begin
              if (!r.lo_next) begin
                next_r.tx = rd_data[15:8];
                next_r.hold = rd_data[7:0];
                next_r.lo_next = 1'b1;
              end else begin
                next_r.tx = r.hold;
                next_r.lo_next = 1'b0;
                next_r.ptr = r.ptr + 8'h01;
              end
              next_r.sda_oe = ~next_r.tx[7];
            end
          end
          default: begin
            if (r.ph == isrp_pkg::ISRP_READ && r.cnt != 4'h0) begin
              next_r.tx = {r.tx[6:0], 1'b0};
              next_r.sda_oe = ~next_r.tx[7];
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.scl1 <= 1'b1;
      r.scl2 <= 1'b1;
      r.scl3 <= 1'b1;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
      r.sda3 <= 1'b1;
      r.ptr <= isrp_pkg::PTR_RST;
    end else begin
      r <= next_r;
    end
  end

  // Slave never drives the clock
  assign bus.s_scl_o = r.zero;
  assign bus.s_scl_oe = r.zero;
  assign bus.s_sda_o = r.zero;
  assign bus.s_sda_oe = r.sda_oe;
  assign ptr = r.ptr;
  assign wr_addr = r.wa;
  assign wr_data = r.wd;
  assign wr_stb = r.stb;
endmodule

// >>> testbench/isrp_properties.sv
/*
  Wire checks on the bus joining the master end and the slave end.
  Assumes the wires are sampled on the shared core clock.
*/
`timescale 1ns/100ps
module isrp_properties #(
  parameter logic [6:0] SLV_ADDR = isrp_pkg::DEV_ADDR
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic m_sda_oe,
  input wire logic s_scl_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic hit;
  logic rd;
  logic dat;
  logic nak;
  logic [3:0] bc;
  logic [7:0] sh;
  wire rise = scl & ~scl_q;
  wire strt = scl & scl_q & sda_q & ~sda;
  wire stp = scl & scl_q & ~sda_q & sda;
  wire ack = rise && bc == 4'h8;
  wire a0 = ack && !dat;
  // ******
  // Byte tracker
  // ******
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      hit <= 1'b0;
      rd <= 1'b0;
      dat <= 1'b0;
      nak <= 1'b0;
      bc <= 4'h0;
      sh <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (strt) begin
        bc <= 4'h0;
        dat <= 1'b0;
        nak <= 1'b0;
      end else if (ack) begin
        bc <= 4'h0;
        dat <= 1'b1;
        // Master refusal in a read: next pulse is the stop
        if (dat && rd) begin
          nak <= sda;
        end
        if (!dat) begin
          hit <= sh[7:1] == SLV_ADDR;
          rd <= sh[0];
        end
      end else if (rise) begin
        bc <= bc + 4'h1;
        sh <= {sh[6:0], sda};
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_no_clock_drive: assert property (!s_scl_oe)
    else $error("slave drove the clock");
  chk_addr_acked: assert property (a0 && sh[7:1] == SLV_ADDR |-> s_sda_oe && !sda)
    else $error("own address not acked");
  chk_foreign_quiet: assert property (a0 && sh[7:1] != SLV_ADDR |-> !s_sda_oe)
    else $error("foreign address acked");
  chk_write_byte_ack: assert property (ack && dat && hit && !rd |-> s_sda_oe && !sda)
    else $error("written byte not acked");
  chk_read_ack_free: assert property (ack && dat && rd |-> !s_sda_oe)
    else $error("slave drove master ack slot");
  chk_hold_while_high: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("slave data moved with clock high");
  chk_write_dir_kept: assert property (rise && dat && !rd && bc != 4'h8 |-> !s_sda_oe)
    else $error("slave drove during write data");
  chk_read_master_off: assert property (rise && dat && rd && !nak && bc != 4'h8 |-> !m_sda_oe)
    else $error("master drove during read data");
  chk_stop_released: assert property (stp |-> !s_sda_oe [*8])
    else $error("slave held data after stop");
  cover property (a0 && sh[7:1] == SLV_ADDR && sh[0]);
  cover property (ack && dat && hit && !rd);
  cover property (ack && dat && rd);
  cover property (stp);
endmodule

// >>> testbench/isrp_tb_top.sv
/*
  Bench: master and slave on one bus; a second bus whose slave has
  another address. Assumes QTR of 4 keeps each command short.
*/
`timescale 1ns/100ps
module i2c_slave_register_port_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cv [2] = '{1'b0, 1'b0};
  logic crw [2] = '{1'b0, 1'b0};
  logic [7:0] creg [2] = '{8'h00, 8'h00};
  logic [15:0] cwd [2] = '{16'h0000, 16'h0000};
  logic rdy [2];
  logic dn [2];
  logic nk [2];
  logic [15:0] rdd [2];
  logic [7:0] ptr, ptr2, wa, wa2;
  logic [15:0] wd, wd2;
  logic stb, stb2;
  logic [15:0] mem [256];
  int fails = 0;
  int checks = 0;
  int nstb = 0;
  int nstb2 = 0;
  int drv2 = 0;
  isrp_if bus_a ();
  isrp_if bus_b ();
  always #20 clk = ~clk;
  isrp_master #(.QTR(4)) i_isrp_master (.clk(clk), .sys_rst(sys_rst), .bus(bus_a.master),
    .cmd_valid(cv[0]), .cmd_rw(crw[0]), .cmd_reg(creg[0]), .cmd_wdata(cwd[0]),
    .cmd_ready(rdy[0]), .done(dn[0]), .rd_data(rdd[0]), .nack_err(nk[0]));
  isrp_master #(.QTR(4)) i_isrp_master_b (.clk(clk), .sys_rst(sys_rst), .bus(bus_b.master),
    .cmd_valid(cv[1]), .cmd_rw(crw[1]), .cmd_reg(creg[1]), .cmd_wdata(cwd[1]),
    .cmd_ready(rdy[1]), .done(dn[1]), .rd_data(rdd[1]), .nack_err(nk[1]));
  isrp_slave i_isrp_slave (.clk(clk), .sys_rst(sys_rst), .bus(bus_a.slave), .ptr(ptr),
    .rd_data(mem[ptr]), .wr_addr(wa), .wr_data(wd), .wr_stb(stb));
  isrp_slave #(.SLV_ADDR(7'h15)) i_isrp_slave_b (.clk(clk), .sys_rst(sys_rst),
    .bus(bus_b.slave), .ptr(ptr2), .rd_data(16'h0F0F), .wr_addr(wa2), .wr_data(wd2),
    .wr_stb(stb2));
  isrp_properties #(.SLV_ADDR(isrp_pkg::DEV_ADDR)) i_isrp_properties (.clk(clk),
    .sys_rst(sys_rst), .m_sda_oe(bus_a.m_sda_oe), .s_scl_oe(bus_a.s_scl_oe),
    .s_sda_oe(bus_a.s_sda_oe), .scl(bus_a.scl), .sda(bus_a.sda));
  // ******
  // Register model and monitors
  // ******
  always @(posedge clk) begin
    if (stb === 1'b1) begin
      mem[wa] <= wd;
      nstb++;
    end
    if (stb2 === 1'b1) nstb2++;
    if (bus_b.s_sda_oe === 1'b1) drv2++;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic hang(input string what);
    fails++;
    $display("MISMATCH t=%0t timeout %s", $time, what);
    give_verdict();
  endtask
  task automatic do_cmd(input int b, input logic rw, input logic [7:0] rg,
      input logic [15:0] d);
    int n;
    n = 0;
    while (rdy[b] !== 1'b1) begin
      @(posedge clk);
      #2;
      n++;
      if (n > 50) hang("ready");
    end
    crw[b] = rw;
    creg[b] = rg;
    cwd[b] = d;
    cv[b] = 1'b1;
    @(posedge clk);
    #2;
    cv[b] = 1'b0;
    n = 0;
    while (dn[b] !== 1'b1) begin
      @(posedge clk);
      #2;
      n++;
      if (n > 3000) hang("done");
    end
  endtask
  task automatic t_word;
    do_cmd(0, 1'b0, 8'h10, 16'hA55A);
    check(nstb, 1, "one strobe");
    check(wa, 8'h10, "write address");
    check(wd, 16'hA55A, "write word");
    check(nk[0], 1'b0, "write acked");
    do_cmd(0, 1'b1, 8'h10, 16'h0000);
    check(rdd[0], 16'hA55A, "read word");
    check(ptr, 8'h11, "pointer advanced");
    check(nstb, 1, "read stores nothing");
    $display("test word done");
  endtask
  task automatic t_table;
    logic [7:0] rg [3] = '{8'h00, 8'hFF, 8'h7E};
    logic [15:0] dv [3] = '{16'h00FF, 16'h8001, 16'hFFFF};
    foreach (rg[i]) do_cmd(0, 1'b0, rg[i], dv[i]);
    foreach (rg[i]) begin
      do_cmd(0, 1'b1, rg[i], 16'h0000);
      check(rdd[0], dv[i], "table read");
      check(ptr, 8'(rg[i] + 8'h01), "pointer wrap");
    end
    check(nstb, 4, "strobe count");
    $display("test table done");
  endtask
  task automatic t_foreign;
    do_cmd(1, 1'b0, 8'h20, 16'h1234);
    check(nk[1], 1'b1, "foreign write refused");
    do_cmd(1, 1'b1, 8'h20, 16'h0000);
    check(nk[1], 1'b1, "foreign read refused");
    check(nstb2, 0, "foreign slave stored");
    check(drv2, 0, "foreign slave drove data");
    check(ptr2, 8'h00, "foreign pointer kept");
    $display("test foreign done");
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (10) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    check(ptr, 8'h00, "pointer at reset");
    t_word();
    t_table();
    t_foreign();
    give_verdict();
  end
endmodule
